// file: rtl/bvs_pkg.sv
/*
 Shared constants, encodings and carrier types for the step-down regulator
 set-point, mode and slew control. Assumes one 100 MHz reference clock.
*/
package bvs_pkg;
   localparam int NUM_CHAN = 6;
   localparam int REF_CLK_MHZ = 100;
   // Set-point codes
   localparam logic [7:0] CODE_MAX_DVS = 8'hB0;
   localparam logic [7:0] CODE_HIGH = 8'hB1;
   localparam logic [7:0] CODE_RESET = 8'h00;
   // Internal clock cycles per 6.25 mV step
   localparam logic [4:0] STEP_UP_SLOW = 5'h10;
   localparam logic [4:0] STEP_DN_SLOW = 5'h18;
   localparam logic [4:0] STEP_UP_FAST = 5'h08;
   localparam logic [4:0] STEP_DN_FAST = 5'h0C;
   // Power-up defaults
   localparam logic [2:0] PHASE_RESET = 3'h7;
   localparam logic [1:0] ILIM_RESET = 2'h0;
   localparam logic [1:0] INIT_LOAD_CYCLES = 2'h2;
   localparam logic [6:0] FREQ_DEFAULT_MHZ = 7'h14;
   // Read data layout of the interrupt field
   localparam int IRQ_STAT_BIT = 0;
   localparam int IRQ_MASK_BIT = 1;

   typedef enum logic [1:0] {
      BVS_MODE_OFF = 2'h0,
      BVS_MODE_PWM = 2'h1,
      BVS_MODE_PFM = 2'h2,
      BVS_MODE_AUTOSKIP = 2'h3
   } bvs_mode_type;

   typedef enum logic [2:0] {
      BVS_FLD_RUN_V = 3'h0,
      BVS_FLD_STBY_V = 3'h1,
      BVS_FLD_RUN_MODE = 3'h2,
      BVS_FLD_STBY_MODE = 3'h3,
      BVS_FLD_RAMP = 3'h4,
      BVS_FLD_ILIM = 3'h5,
      BVS_FLD_PHASE = 3'h6,
      BVS_FLD_IRQ = 3'h7
   } bvs_field_type;

   typedef enum {BVS_RS_IDLE, BVS_RS_SLEW, BVS_RS_DROP, BVS_RS_RELOAD} bvs_rstate_type;

   typedef struct packed {
      logic [7:0] default_voltage_fuse;
      logic default_ramp_fuse;
      logic [1:0] inductor_sel_fuse;
      logic in_powerup_seq;
   } bvs_fuse_type;

   typedef struct packed {
      logic [7:0] run_voltage_code;
      logic [7:0] standby_voltage_code;
      bvs_mode_type run_op_mode;
      bvs_mode_type standby_op_mode;
      logic ramp_speed_sel;
      logic [1:0] current_limit_sel;
      logic [2:0] phase_shift_sel;
   } bvs_cfg_type;

   typedef struct packed {
      logic [7:0] vout_code;
      logic enabled;
      bvs_mode_type mode;
      logic [1:0] current_limit_sel;
      logic [2:0] phase_shift_sel;
      logic [1:0] inductor_sel;
   } bvs_out_type;

   // Internal clock frequency in MHz for a frequency code
   function automatic logic [6:0] bvs_freq_mhz(input logic [3:0] code);
      logic [6:0] f;
      f = FREQ_DEFAULT_MHZ;
      if (code <= 4'h4) begin
         f = 7'(FREQ_DEFAULT_MHZ + 7'(code));
      end else if (code >= 4'h9 && code <= 4'hC) begin
         f = 7'(7'h10 + 7'(code - 4'h9));
      end
      return f;
   endfunction : bvs_freq_mhz
endpackage : bvs_pkg

// file: rtl/bvs_ramp.sv
/*
 One regulator channel's output sequencer: steps the applied code toward the
 target, hops through an off phase to and from the high set-point.
 Assumes int_tick is a single-cycle pulse at the internal clock rate.
*/
`timescale 1ns/1ns
module bvs_ramp
   import bvs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic int_tick,
   input wire logic [7:0] target_code,
   input wire logic fast,
   input wire bvs_mode_type mode,
   output logic [7:0] vout_code_r,
   output logic enable_r,
   output logic step_r
);
   logic [7:0] tgt_r;
   logic [4:0] cnt_r;
   logic [4:0] limit;
   logic rising;
   logic hop_need;
   bvs_rstate_type state_r;

   // Hold last legal target; reserved codes leave output alone
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tgt_r <= CODE_RESET;
      end else if (target_code <= CODE_HIGH) begin
         tgt_r <= target_code;
      end
   end

   // Step spacing by direction and speed
   always_comb begin
      rising = tgt_r > vout_code_r;
      hop_need = (vout_code_r == CODE_HIGH) != (tgt_r == CODE_HIGH);
      if (fast) begin
         limit = rising ? STEP_UP_FAST : STEP_DN_FAST;
      end else begin
         limit = rising ? STEP_UP_SLOW : STEP_DN_SLOW;
      end
   end

   // Sequencer: gradual slewing inside the low range, off/on hop otherwise
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= BVS_RS_IDLE;
         vout_code_r <= CODE_RESET;
         enable_r <= 1'b0;
         cnt_r <= 5'h00;
         step_r <= 1'b0;
      end else begin
         step_r <= 1'b0;
         enable_r <= mode != BVS_MODE_OFF;
         unique case (state_r)
            BVS_RS_IDLE: begin
               cnt_r <= 5'h00;
               if (vout_code_r != tgt_r) begin
                  state_r <= hop_need ? BVS_RS_DROP : BVS_RS_SLEW;
                  if (hop_need) begin
                     enable_r <= 1'b0;
                  end
               end
            end
            BVS_RS_SLEW: begin
               if (vout_code_r == tgt_r) begin
                  state_r <= BVS_RS_IDLE;
               end else if (hop_need) begin
                  state_r <= BVS_RS_DROP;
                  enable_r <= 1'b0;
               end else if (int_tick) begin
                  if (cnt_r + 5'h01 >= limit) begin
                     cnt_r <= 5'h00;
                     step_r <= 1'b1;
                     vout_code_r <= rising ? 8'(vout_code_r + 8'h01) : 8'(vout_code_r - 8'h01);
                  end else begin
                     cnt_r <= 5'(cnt_r + 5'h01);
                  end
               end
            end
            BVS_RS_DROP: begin
               enable_r <= 1'b0;
               state_r <= BVS_RS_RELOAD;
            end
            BVS_RS_RELOAD: begin
               vout_code_r <= tgt_r;
               state_r <= BVS_RS_IDLE;
            end
         endcase
      end
   end

   // High set-point entered or left only with the regulator off
   property p_hop_off;
      @(posedge ref_clk) disable iff (rst)
      ((vout_code_r == CODE_HIGH) != ($past(vout_code_r) == CODE_HIGH)) |-> !$past(enable_r);
   endproperty
   a_hop_off: assert property (p_hop_off) else $error("high set-point changed while enabled");

   // Inside the low range the code moves one step at a time
   property p_single_step;
      @(posedge ref_clk) disable iff (rst)
      ($changed(vout_code_r) && vout_code_r <= CODE_MAX_DVS && $past(vout_code_r) <= CODE_MAX_DVS)
         |-> (vout_code_r - $past(vout_code_r) == 8'h01 || $past(vout_code_r) - vout_code_r == 8'h01);
   endproperty
   a_single_step: assert property (p_single_step) else $error("slew moved more than one code");

   // Reserved target codes do not move the held target
   property p_reserved_held;
      @(posedge ref_clk) disable iff (rst)
      (target_code > CODE_HIGH) |=> $stable(tgt_r);
   endproperty
   a_reserved_held: assert property (p_reserved_held) else $error("reserved code taken");

   // Steps need at least eight internal ticks, so never closer than eight cycles
   property p_step_spacing;
      @(posedge ref_clk) disable iff (rst)
      step_r |=> !step_r [*8];
   endproperty
   a_step_spacing: assert property (p_step_spacing) else $error("slew steps too close");
endmodule : bvs_ramp

// file: rtl/bvs_ctrl.sv
/*
 Six-channel step-down regulator control: run and standby set-points and
 modes, power-up load from fuses, slew timing from an emulated internal
 clock, current limit, phase and inductor selection, mode-change interrupt.
 Assumes a host-side serial front end on ref_clk drives the write and read
 ports; fuses, standby and clock code arrive from pins.
*/
`timescale 1ns/1ns
module bvs_ctrl
   import bvs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire bvs_fuse_type [NUM_CHAN-1:0] fuse_in,
   input wire logic standby_in,
   input wire logic [3:0] internal_clock_freq_code,
   input wire logic host_wr,
   input wire logic [2:0] host_chan,
   input wire bvs_field_type host_field,
   input wire logic [7:0] host_wdata,
   input wire logic [2:0] rd_chan,
   input wire bvs_field_type rd_field,
   output logic [7:0] rd_data_r,
   output bvs_out_type [NUM_CHAN-1:0] chan_out,
   output logic [NUM_CHAN-1:0] op_mode_change_irq,
   output logic irq_out_n
);
   bvs_fuse_type [NUM_CHAN-1:0] fuse_s1_r;
   bvs_fuse_type [NUM_CHAN-1:0] fuse_r;
   logic standby_s1_r;
   logic standby_r;
   logic [3:0] freq_s1_r;
   logic [3:0] freq_r;
   logic [1:0] init_cnt_r;
   logic init_done_r;
   logic init_load;
   bvs_cfg_type [NUM_CHAN-1:0] cfg_r;
   bvs_mode_type [NUM_CHAN-1:0] act_mode_r;
   bvs_mode_type [NUM_CHAN-1:0] act_mode_nxt;
   logic [7:0] target [NUM_CHAN];
   logic [NUM_CHAN-1:0] irq_r;
   logic [NUM_CHAN-1:0] mask_r;
   logic [NUM_CHAN-1:0] irq_set;
   logic [NUM_CHAN-1:0] irq_clr;
   logic irq_out_n_r;
   logic [7:0] vout [NUM_CHAN];
   logic [NUM_CHAN-1:0] en;
   logic [6:0] acc_r;
   logic [7:0] acc_sum;
   logic int_tick_r;
   logic host_ok;

   // Pin inputs pass two flip-flops
   always_ff @(posedge ref_clk) begin
      fuse_s1_r <= fuse_in;
      fuse_r <= fuse_s1_r;
      standby_s1_r <= standby_in;
      standby_r <= standby_s1_r;
      freq_s1_r <= internal_clock_freq_code;
      freq_r <= freq_s1_r;
   end

   // Power-up load once the fuse synchronisers are filled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         init_cnt_r <= 2'h0;
         init_done_r <= 1'b0;
      end else if (!init_done_r) begin
         if (init_load) begin
            init_done_r <= 1'b1;
         end else begin
            init_cnt_r <= 2'(init_cnt_r + 2'h1);
         end
      end
   end

   assign init_load = !init_done_r && (init_cnt_r == INIT_LOAD_CYCLES);
   assign host_ok = host_wr && init_done_r && (host_chan < 3'(NUM_CHAN));

   // Internal clock emulated by a phase accumulator on the reference clock
   assign acc_sum = 8'(acc_r) + 8'(bvs_freq_mhz(freq_r));

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc_r <= 7'h00;
         int_tick_r <= 1'b0;
      end else if (acc_sum >= 8'(REF_CLK_MHZ)) begin
         acc_r <= 7'(acc_sum - 8'(REF_CLK_MHZ));
         int_tick_r <= 1'b1;
      end else begin
         acc_r <= 7'(acc_sum);
         int_tick_r <= 1'b0;
      end
   end

   // Per-channel settings: fuse load at power-up, host writes afterwards
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            cfg_r[i].run_voltage_code <= CODE_RESET;
            cfg_r[i].standby_voltage_code <= CODE_RESET;
            cfg_r[i].run_op_mode <= BVS_MODE_OFF;
            cfg_r[i].standby_op_mode <= BVS_MODE_OFF;
            cfg_r[i].ramp_speed_sel <= 1'b0;
            cfg_r[i].current_limit_sel <= ILIM_RESET;
            cfg_r[i].phase_shift_sel <= PHASE_RESET;
         end
      end else if (init_load) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            cfg_r[i].run_voltage_code <= fuse_r[i].default_voltage_fuse;
            cfg_r[i].standby_voltage_code <= fuse_r[i].default_voltage_fuse;
            cfg_r[i].run_op_mode <= fuse_r[i].in_powerup_seq ?
               BVS_MODE_AUTOSKIP : BVS_MODE_OFF;
            cfg_r[i].standby_op_mode <= fuse_r[i].in_powerup_seq ?
               BVS_MODE_AUTOSKIP : BVS_MODE_OFF;
            cfg_r[i].ramp_speed_sel <= fuse_r[i].default_ramp_fuse;
            cfg_r[i].phase_shift_sel <= PHASE_RESET;
         end
      end else if (host_ok) begin
         unique case (host_field)
            BVS_FLD_RUN_V: cfg_r[host_chan].run_voltage_code <= host_wdata;
            BVS_FLD_STBY_V: cfg_r[host_chan].standby_voltage_code <= host_wdata;
            BVS_FLD_RUN_MODE: cfg_r[host_chan].run_op_mode <= bvs_mode_type'(host_wdata[1:0]);
            BVS_FLD_STBY_MODE: begin
               cfg_r[host_chan].standby_op_mode <= bvs_mode_type'(host_wdata[1:0]);
            end
            BVS_FLD_RAMP: cfg_r[host_chan].ramp_speed_sel <= host_wdata[0];
            BVS_FLD_ILIM: cfg_r[host_chan].current_limit_sel <= host_wdata[1:0];
            BVS_FLD_PHASE: cfg_r[host_chan].phase_shift_sel <= host_wdata[2:0];
            BVS_FLD_IRQ: begin
            end
         endcase
      end
   end

   // Active mode and set-point follow the system state
   always_comb begin
      for (int i = 0; i < NUM_CHAN; i++) begin
         act_mode_nxt[i] = standby_r ? cfg_r[i].standby_op_mode : cfg_r[i].run_op_mode;
         target[i] = standby_r ? cfg_r[i].standby_voltage_code : cfg_r[i].run_voltage_code;
         irq_set[i] = init_done_r && (act_mode_nxt[i] != act_mode_r[i]);
         irq_clr[i] = host_ok && host_field == BVS_FLD_IRQ && host_chan == 3'(i)
            && host_wdata[IRQ_STAT_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            act_mode_r[i] <= BVS_MODE_OFF;
         end
      end else begin
         act_mode_r <= act_mode_nxt;
      end
   end

   // Sticky mode-change flags; a new change beats a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_r <= '0;
         mask_r <= '0;
         irq_out_n_r <= 1'b1;
      end else begin
         irq_r <= irq_set | (irq_r & ~irq_clr);
         if (host_ok && host_field == BVS_FLD_IRQ) begin
            mask_r[host_chan] <= host_wdata[IRQ_MASK_BIT];
         end
         irq_out_n_r <= ~|(irq_r & ~mask_r);
      end
   end

   // One output sequencer per channel
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
      bvs_ramp u_ramp (
         .ref_clk(ref_clk),
         .rst(rst),
         .int_tick(int_tick_r),
         .target_code(target[g]),
         .fast(cfg_r[g].ramp_speed_sel),
         .mode(act_mode_r[g]),
         .vout_code_r(vout[g]),
         .enable_r(en[g]),
         .step_r()
      );
      assign chan_out[g].vout_code = vout[g];
      assign chan_out[g].enabled = en[g];
      assign chan_out[g].mode = act_mode_r[g];
      assign chan_out[g].current_limit_sel = cfg_r[g].current_limit_sel;
      assign chan_out[g].phase_shift_sel = cfg_r[g].phase_shift_sel;
      assign chan_out[g].inductor_sel = fuse_r[g].inductor_sel_fuse;
   end

   // Registered readback of the selected field
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data_r <= 8'h00;
      end else if (rd_chan >= 3'(NUM_CHAN)) begin
         rd_data_r <= 8'h00;
      end else begin
         unique case (rd_field)
            BVS_FLD_RUN_V: rd_data_r <= cfg_r[rd_chan].run_voltage_code;
            BVS_FLD_STBY_V: rd_data_r <= cfg_r[rd_chan].standby_voltage_code;
            BVS_FLD_RUN_MODE: rd_data_r <= {6'h00, cfg_r[rd_chan].run_op_mode};
            BVS_FLD_STBY_MODE: rd_data_r <= {6'h00, cfg_r[rd_chan].standby_op_mode};
            BVS_FLD_RAMP: rd_data_r <= {7'h00, cfg_r[rd_chan].ramp_speed_sel};
            BVS_FLD_ILIM: rd_data_r <= {6'h00, cfg_r[rd_chan].current_limit_sel};
            BVS_FLD_PHASE: rd_data_r <= {5'h00, cfg_r[rd_chan].phase_shift_sel};
            BVS_FLD_IRQ: rd_data_r <= {6'h00, mask_r[rd_chan], irq_r[rd_chan]};
         endcase
      end
   end

   assign op_mode_change_irq = irq_r;
   assign irq_out_n = irq_out_n_r;

   // A mode change after power-up sets the channel flag on the next edge
   property p_mode_irq;
      @(posedge ref_clk) disable iff (rst)
      (init_done_r && act_mode_nxt[0] != act_mode_r[0]) |=> irq_r[0];
   endproperty
   a_mode_irq: assert property (p_mode_irq) else $error("mode change not flagged");

   // Interrupt pin follows unmasked flags one cycle later
   property p_irq_pin;
      @(posedge ref_clk) disable iff (rst)
      ##1 (irq_out_n_r == !$past(|(irq_r & ~mask_r)));
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");

   // Power-up set-points equal the channel fuse
   property p_fuse_load;
      @(posedge ref_clk) disable iff (rst)
      init_load |=> (cfg_r[0].run_voltage_code == $past(fuse_r[0].default_voltage_fuse)
         && cfg_r[0].standby_voltage_code == $past(fuse_r[0].default_voltage_fuse));
   endproperty
   a_fuse_load: assert property (p_fuse_load) else $error("set-point not loaded from fuse");

   // Power-up modes depend on sequence membership
   property p_mode_load;
      @(posedge ref_clk) disable iff (rst)
      init_load |=> (cfg_r[1].run_op_mode == ($past(fuse_r[1].in_powerup_seq) ?
         BVS_MODE_AUTOSKIP : BVS_MODE_OFF));
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("power-up mode wrong");

   // Phase defaults to PHASE_RESET (code 7) at power-up
   property p_phase_default;
      @(posedge ref_clk) disable iff (rst)
      init_load |=> cfg_r[2].phase_shift_sel == PHASE_RESET;
   endproperty
   a_phase_default: assert property (p_phase_default) else $error("phase default wrong");

   // Host ramp write lands one cycle later
   property p_ramp_write;
      @(posedge ref_clk) disable iff (rst)
      (host_ok && host_field == BVS_FLD_RAMP && host_chan == 3'h0)
         |=> cfg_r[0].ramp_speed_sel == $past(host_wdata[0]);
   endproperty
   a_ramp_write: assert property (p_ramp_write) else $error("ramp select not written");

   // A clear with no new change drops the flag on the next edge
   property p_irq_clear;
      @(posedge ref_clk) disable iff (rst)
      (irq_clr[3] && !irq_set[3]) |=> !irq_r[3];
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("mode flag not cleared");

   // Host current limit write lands one cycle later
   property p_ilim_write;
      @(posedge ref_clk) disable iff (rst)
      (host_ok && host_field == BVS_FLD_ILIM && host_chan == 3'h5)
         |=> cfg_r[5].current_limit_sel == $past(host_wdata[1:0]);
   endproperty
   a_ilim_write: assert property (p_ilim_write) else $error("current limit not written");

   // Host phase write lands one cycle later
   property p_phase_write;
      @(posedge ref_clk) disable iff (rst)
      (host_ok && host_field == BVS_FLD_PHASE && host_chan == 3'h5)
         |=> cfg_r[5].phase_shift_sel == $past(host_wdata[2:0]);
   endproperty
   a_phase_write: assert property (p_phase_write) else $error("phase not written");

   // Power-up standby mode depends on sequence membership
   property p_stby_mode_load;
      @(posedge ref_clk) disable iff (rst)
      init_load |=> (cfg_r[4].standby_op_mode == ($past(fuse_r[4].in_powerup_seq) ?
         BVS_MODE_AUTOSKIP : BVS_MODE_OFF));
   endproperty
   a_stby_mode_load: assert property (p_stby_mode_load) else $error("standby mode wrong");
endmodule : bvs_ctrl

// file: bench/bvs_host.sv
/*
 Host model: issues single-cycle register writes to the regulator control.
 Assumes the caller waits out reset and the power-up load before writing.
*/
`timescale 1ns/1ns
module bvs_host
   import bvs_pkg::*;
(
   input wire logic ref_clk,
   output logic host_wr,
   output logic [2:0] host_chan,
   output bvs_field_type host_field,
   output logic [7:0] host_wdata
);
   // Idle bus at time zero
   initial begin
      host_wr = 1'b0;
      host_chan = 3'h0;
      host_field = BVS_FLD_RUN_V;
      host_wdata = 8'h00;
   end

   // One write held for one edge; data scrambled once released
   task automatic wr(input logic [2:0] c, input bvs_field_type f, input logic [7:0] d);
      @(posedge ref_clk);
      host_wr <= 1'b1;
      host_chan <= c;
      host_field <= f;
      host_wdata <= d;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      host_wdata <= ~d;
   endtask : wr

   // Bring a channel up in PWM so its output is enabled while in run state
   task automatic start_pwm(input logic [2:0] c);
      wr(c, BVS_FLD_RUN_MODE, 8'h01);
   endtask : start_pwm
endmodule : bvs_host

// file: bench/tb_top.sv
/*
 Self-checking bench for the regulator control block.
 Assumes the design's assertions sit inside its own files.
*/
`timescale 1ns/1ns
module tb_top
   import bvs_pkg::*;
;
   typedef struct {logic [2:0] k; logic [2:0] c; logic [7:0] v;} bvs_note_type;
   localparam logic [5:0] SEQ = 6'h2D;
   logic ref_clk, rst, standby_in, pend, arm, host_wr, irq_out_n;
   logic [3:0] internal_clock_freq_code;
   logic [2:0] rd_chan, host_chan;
   bvs_field_type rd_field, host_field;
   logic [7:0] host_wdata, rd_data_r, prev, cnt, f0;
   bvs_fuse_type [NUM_CHAN-1:0] fuse_in;
   bvs_out_type [NUM_CHAN-1:0] chan_out;
   logic [NUM_CHAN-1:0] op_mode_change_irq;
   int mismatches, check_count, seed, i, mhz;
   bvs_note_type q[$];
   bvs_note_type n;
   string nm[8] = '{"readback", "vout", "enabled", "mode", "irq", "phase", "ilim", "ind"};

   bvs_ctrl dut (.ref_clk(ref_clk), .rst(rst), .fuse_in(fuse_in), .standby_in(standby_in),
      .internal_clock_freq_code(internal_clock_freq_code), .host_wr(host_wr),
      .host_chan(host_chan), .host_field(host_field), .host_wdata(host_wdata),
      .rd_chan(rd_chan), .rd_field(rd_field), .rd_data_r(rd_data_r), .chan_out(chan_out),
      .op_mode_change_irq(op_mode_change_irq), .irq_out_n(irq_out_n));
   bvs_host host (.ref_clk(ref_clk), .host_wr(host_wr), .host_chan(host_chan),
      .host_field(host_field), .host_wdata(host_wdata));

   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] seen(input logic [2:0] k, input logic [2:0] c);
      case (k)
         3'h0: return rd_data_r;
         3'h1: return chan_out[c].vout_code;
         3'h2: return {7'h00, chan_out[c].enabled};
         3'h3: return {6'h00, chan_out[c].mode};
         3'h4: return {6'h00, op_mode_change_irq[c], irq_out_n};
         3'h5: return {5'h00, chan_out[c].phase_shift_sel};
         3'h6: return {6'h00, chan_out[c].current_limit_sel};
         default: return {6'h00, chan_out[c].inductor_sel};
      endcase
   endfunction : seen

   task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] v);
      check_count++;
      if (v !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", s, e, v);
      end
   endtask : cmp

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict

   // Note an expectation; the monitor compares at the next edge
   task automatic chk(input logic [2:0] k, input logic [2:0] c, input logic [7:0] v);
      q.push_back('{k, c, v});
      pend <= 1'b1;
      @(posedge ref_clk);
      pend <= 1'b0;
      @(posedge ref_clk);
   endtask : chk

   task automatic rd(input logic [2:0] c, input bvs_field_type f, input logic [7:0] e);
      @(posedge ref_clk);
      rd_chan <= c;
      rd_field <= f;
      @(posedge ref_clk);
      chk(3'h0, 3'h0, e);
   endtask : rd

   // Bounded wait for a channel's applied code
   task automatic wv(input logic [2:0] c, input logic [7:0] v);
      for (int t = 0; t < 9000 && chan_out[c].vout_code !== v; t++) begin
         @(posedge ref_clk);
      end
   endtask : wv

   // Move channel 0 from s to t; the gap between first and second step is noted
   task automatic slew(input logic [7:0] s, input logic [7:0] t, input logic [7:0] e);
      host.wr(3'h0, BVS_FLD_RUN_V, t);
      for (int w = 0; w < 400 && chan_out[0].vout_code === s; w++) begin
         @(posedge ref_clk);
      end
      arm <= 1'b1;
      q.push_back('{3'h0, 3'h0, e});
      wv(3'h0, t > s ? s + 8'h02 : s - 8'h02);
      arm <= 1'b0;
      wv(3'h0, t);
   endtask : slew

   // Compare oldest note with the outputs; time the steps of channel 0
   always @(posedge ref_clk) begin
      if (pend && q.size() > 0) begin
         n = q.pop_front();
         cmp(nm[n.k], n.v, seen(n.k, n.c));
      end
      prev <= chan_out[0].vout_code;
      if (chan_out[0].vout_code !== prev) begin
         if (arm && q.size() > 0) begin
            n = q.pop_front();
            cmp("step gap", n.v, cnt);
         end
         cnt <= 8'h01;
      end else if (cnt != 8'hFF) begin
         cnt <= cnt + 8'h01;
      end
   end

   // Cut a hang short
   initial begin
      repeat (60000) @(posedge ref_clk);
      mismatches++;
      print_verdict();
   end

   // Main sequence
   initial begin
      seed = 32'hb506;
      rst = 1'b1;
      standby_in = 1'b0;
      internal_clock_freq_code = 4'h0;
      rd_chan = 3'h0;
      rd_field = BVS_FLD_RUN_V;
      pend = 1'b0;
      arm = 1'b0;
      prev = 8'h00;
      cnt = 8'h00;
      for (i = 0; i < NUM_CHAN; i++) begin
         fuse_in[i] = 12'($random(seed));
         fuse_in[i].default_voltage_fuse[7:6] = 2'h0;
         fuse_in[i].in_powerup_seq = SEQ[i];
      end
      f0 = fuse_in[0].default_voltage_fuse;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (i = 0; i < NUM_CHAN; i++) begin
         rd(3'(i), BVS_FLD_RUN_V, fuse_in[i].default_voltage_fuse);
         rd(3'(i), BVS_FLD_STBY_V, fuse_in[i].default_voltage_fuse);
         rd(3'(i), BVS_FLD_RUN_MODE, SEQ[i] ? 8'h03 : 8'h00);
         rd(3'(i), BVS_FLD_STBY_MODE, SEQ[i] ? 8'h03 : 8'h00);
         rd(3'(i), BVS_FLD_RAMP, {7'h00, fuse_in[i].default_ramp_fuse});
         rd(3'(i), BVS_FLD_PHASE, 8'h07);
         chk(3'h7, 3'(i), {6'h00, fuse_in[i].inductor_sel_fuse});
         host.wr(3'(i), BVS_FLD_IRQ, 8'h01);
      end
      for (i = 0; i < NUM_CHAN; i++) begin
         wv(3'(i), SEQ[i] ? fuse_in[i].default_voltage_fuse : chan_out[i].vout_code);
         if (SEQ[i]) begin
            chk(3'h1, 3'(i), fuse_in[i].default_voltage_fuse);
         end
      end
      // Step gaps for both speeds at 20 MHz and 16 MHz
      for (i = 0; i < 4; i++) begin
         mhz = i[1] ? 16 : 20;
         internal_clock_freq_code <= i[1] ? 4'h9 : 4'h0;
         host.wr(3'h0, BVS_FLD_RAMP, {7'h00, i[0]});
         slew(f0, f0 + 8'h03, 8'((i[0] ? STEP_UP_FAST : STEP_UP_SLOW) * 100 / mhz));
         slew(f0 + 8'h03, f0, 8'((i[0] ? STEP_DN_FAST : STEP_DN_SLOW) * 100 / mhz));
      end
      // Hop to and from the high set-point
      host.start_pwm(3'h1);
      host.wr(3'h1, BVS_FLD_RUN_V, CODE_HIGH);
      repeat (8) @(posedge ref_clk);
      chk(3'h1, 3'h1, CODE_HIGH);
      chk(3'h2, 3'h1, 8'h01);
      host.wr(3'h1, BVS_FLD_RUN_V, 8'h20);
      repeat (8) @(posedge ref_clk);
      chk(3'h1, 3'h1, 8'h20);
      // Reserved code stored, output held
      host.wr(3'h2, BVS_FLD_RUN_V, 8'hB2);
      rd(3'h2, BVS_FLD_RUN_V, 8'hB2);
      repeat (130) @(posedge ref_clk);
      chk(3'h1, 3'h2, fuse_in[2].default_voltage_fuse);
      // Every mode code, flag and pin, then masked
      host.wr(3'h1, BVS_FLD_IRQ, 8'h01);
      for (i = 1; i < 5; i++) begin
         host.wr(3'h3, BVS_FLD_RUN_MODE, 8'(i % 4));
         repeat (3) @(posedge ref_clk);
         chk(3'h3, 3'h3, 8'(i % 4));
         chk(3'h2, 3'h3, {7'h00, i != 4});
         rd(3'h3, BVS_FLD_IRQ, 8'h01);
         chk(3'h4, 3'h3, 8'h02);
         host.wr(3'h3, BVS_FLD_IRQ, 8'h01);
         rd(3'h3, BVS_FLD_IRQ, 8'h00);
         chk(3'h4, 3'h3, 8'h01);
      end
      host.wr(3'h3, BVS_FLD_IRQ, 8'h02);
      host.wr(3'h3, BVS_FLD_RUN_MODE, 8'h01);
      repeat (3) @(posedge ref_clk);
      rd(3'h3, BVS_FLD_IRQ, 8'h03);
      chk(3'h4, 3'h3, 8'h03);
      // Standby set-point and mode
      host.wr(3'h4, BVS_FLD_STBY_MODE, 8'h02);
      host.wr(3'h4, BVS_FLD_STBY_V, 8'h30);
      standby_in <= 1'b1;
      wv(3'h4, 8'h30);
      chk(3'h1, 3'h4, 8'h30);
      chk(3'h3, 3'h4, 8'h02);
      chk(3'h3, 3'h0, 8'h03);
      standby_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(3'h3, 3'h4, 8'h00);
      // Phase and current limit codes; unmapped channel
      for (i = 0; i < 8; i++) begin
         host.wr(3'h5, BVS_FLD_PHASE, 8'(i));
         host.wr(3'h5, BVS_FLD_ILIM, 8'(i % 4));
         repeat (2) @(posedge ref_clk);
         chk(3'h5, 3'h5, 8'(i));
         chk(3'h6, 3'h5, 8'(i % 4));
      end
      host.wr(3'h6, BVS_FLD_RUN_V, 8'h55);
      rd(3'h6, BVS_FLD_RUN_V, 8'h00);
      rd(3'h5, BVS_FLD_RUN_V, fuse_in[5].default_voltage_fuse);
      print_verdict();
   end
endmodule : tb_top
